// [design/rpms_pkg.sv]
package rpms_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] CSC_OFFSET = 8'h00;
	localparam logic [7:0] STAT_OFFSET = 8'h04;
	localparam logic [7:0] CSC_RESET = 8'h01;
	localparam logic [7:0] CSC_PD_MASK = 8'hdc;
	localparam int CSC_STANDBY_BIT = 7;
	localparam int CSC_HALF_BIT = 4;
	localparam int CSC_RF_BIT = 5;
	localparam int CSC_RXONLY_BIT = 1;
	localparam int CSC_SUPPLY5_BIT = 0;
	localparam int WAKE_WINDOW_US = 100;
	localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_US * CLK_MHZ;
	localparam int STANDBY_REC_US = 100;
	localparam int STANDBY_REC_CYC = STANDBY_REC_US * CLK_MHZ;
	localparam int MODE1_REC_US = 25;
	localparam int MODE1_REC_CYC = MODE1_REC_US * CLK_MHZ;
	localparam int SETTLE_CYC_DEF = 1000;
	localparam int AUX_DIV = 1667;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		RPMS_OFF, RPMS_SLEEP, RPMS_SETTLE, RPMS_WAKE_WAIT, RPMS_ACTIVE
	} rpms_state_e;
	typedef enum logic [2:0] {
		RPMS_M_OFF, RPMS_M_SLEEP, RPMS_M_STANDBY, RPMS_M_1,
		RPMS_M_2, RPMS_M_3, RPMS_M_4
	} rpms_mode_e;
endpackage

// [design/rpms_axil_slave.sv]
`timescale 1ns/1ps
module rpms_axil_slave (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side.
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok,
	input wire logic wr_ok
);
	import rpms_pkg::*;
	typedef struct packed {
		logic aw_full;
		logic w_full;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
	} rpms_bus_s;
	rpms_bus_s st, next_st;
	logic do_wr;

	// Readies are held in flops so no bus output hangs on a gate path.
	assign awready = st.aw_rdy;
	assign wready = st.w_rdy;
	assign arready = st.ar_rdy;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign do_wr = st.aw_full && st.w_full && !st.bvalid;
	assign wr_en = do_wr;
	assign wr_addr = st.awaddr;
	assign wr_data = st.wdata;
	assign wr_strb = st.wstrb;
	assign rd_addr = araddr;

	always_comb begin
		next_st = st;
		if (awvalid && awready) begin
			next_st.aw_full = 1'b1;
			next_st.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			next_st.w_full = 1'b1;
			next_st.wdata = wdata;
			next_st.wstrb = wstrb;
		end
		if (do_wr) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (arvalid && arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_ok ? rd_data : 32'h0000_0000;
			next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		next_st.aw_rdy = !next_st.aw_full && !next_st.bvalid;
		next_st.w_rdy = !next_st.w_full && !next_st.bvalid;
		next_st.ar_rdy = !next_st.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// [design/rpms_sequencer.sv]
`timescale 1ns/1ps
module rpms_sequencer #(
	parameter int SETTLE_CYC = rpms_pkg::SETTLE_CYC_DEF,
	parameter int WAKE_CYC = rpms_pkg::WAKE_WINDOW_CYC,
	parameter int STANDBY_CYC = rpms_pkg::STANDBY_REC_CYC,
	parameter int MODE1_CYC = rpms_pkg::MODE1_REC_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Enable pins from the host.
	input wire logic main_enable,
	input wire logic secondary_wake_pin,
	// AXI4-Lite register port.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Power controls.
	output logic digital_supply_on,
	output logic oscillator_on,
	output logic transmitter_on,
	output logic transmitter_half_power,
	output logic receiver_on,
	output logic supply_5v_config,
	output logic host_clock_output,
	output logic host_clock_fast,
	output logic host_ready,
	output logic full_operation
);
	import rpms_pkg::*;

	typedef struct packed {
		logic [1:0] en_meta;
		logic [1:0] en_sync;
		logic [1:0] wk_meta;
		logic [1:0] wk_sync;
		logic wk_prev;
		rpms_state_e state;
		logic pin_wake;
		logic [31:0] cnt;
		logic [7:0] csc;
		rpms_mode_e mode;
		logic [31:0] rec_cnt;
		logic [15:0] div_cnt;
		logic aux_clk;
		logic dsup;
		logic osc;
		logic tx;
		logic txh;
		logic rx;
		logic s5;
		logic clk_out;
		logic fast;
		logic ready;
		logic full_op;
	} rpms_seq_s;

	rpms_seq_s st, next_st;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	logic en_s;
	logic wk_s;
	logic aux_tick;

	// Picks the operating mode from the control byte.
	function automatic rpms_mode_e decode_mode(input logic [7:0] c);
		if (c[CSC_STANDBY_BIT])
			return RPMS_M_STANDBY;
		else if (c[CSC_RF_BIT])
			return c[CSC_HALF_BIT] ? RPMS_M_3 : RPMS_M_4;
		else if (c[CSC_RXONLY_BIT])
			return RPMS_M_2;
		else
			return RPMS_M_1;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		return a == CSC_OFFSET || a == STAT_OFFSET;
	endfunction

	rpms_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok),
		.wr_ok(wr_ok)
	);

	assign wr_ok = addr_known(wr_addr);
	assign rd_ok = addr_known(rd_addr);
	assign en_s = st.en_sync[0];
	assign wk_s = st.wk_sync[0];
	// The divider constant is one whole slow period, so tick every half.
	assign aux_tick = st.div_cnt == 16'(AUX_DIV / 2 - 1);

	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_addr == CSC_OFFSET)
			rd_data = {24'h00_0000, st.csc};
		else if (rd_addr == STAT_OFFSET)
			rd_data = {24'h00_0000, st.ready, st.fast, st.mode, st.state};
	end

	always_comb begin
		next_st = st;
		// Only the second stage feeds logic; the first is metastability guard.
		next_st.en_meta = {main_enable, 1'b0};
		next_st.en_sync = {1'b0, st.en_meta[1]};
		next_st.wk_meta = {secondary_wake_pin, 1'b0};
		next_st.wk_sync = {1'b0, st.wk_meta[1]};
		next_st.wk_prev = wk_s;
		next_st.div_cnt = aux_tick ? 16'h0000 : st.div_cnt + 16'h0001;
		if (aux_tick)
			next_st.aux_clk = !st.aux_clk;
		if (st.cnt != 32'h0000_0000)
			next_st.cnt = st.cnt - 32'h0000_0001;
		if (st.rec_cnt != 32'h0000_0000)
			next_st.rec_cnt = st.rec_cnt - 32'h0000_0001;
		if (wr_en && wr_addr == CSC_OFFSET && wr_strb[0])
			next_st.csc = wr_data[7:0];

		unique case (st.state)
			RPMS_OFF: begin
				if (en_s || (wk_s && !st.wk_prev)) begin
					next_st.state = RPMS_SETTLE;
					next_st.pin_wake = !en_s;
					next_st.cnt = 32'(SETTLE_CYC);
				end else if (wk_s) begin
					next_st.state = RPMS_SLEEP;
				end
			end
			RPMS_SLEEP: begin
				if (en_s) begin
					next_st.state = RPMS_SETTLE;
					next_st.pin_wake = 1'b0;
					next_st.cnt = 32'(SETTLE_CYC);
				end else if (!wk_s) begin
					next_st.state = RPMS_OFF;
				end
			end
			RPMS_SETTLE: begin
				// A settled regulator and oscillator gate the clock switch.
				if (st.cnt == 32'h0000_0000) begin
					next_st.state = st.pin_wake ? RPMS_WAKE_WAIT : RPMS_ACTIVE;
					next_st.cnt = 32'(WAKE_CYC);
				end
			end
			RPMS_WAKE_WAIT: begin
				if (en_s)
					next_st.state = RPMS_ACTIVE;
				else if (st.cnt == 32'h0000_0000)
					next_st.state = wk_s ? RPMS_SLEEP : RPMS_OFF;
			end
			RPMS_ACTIVE: begin
				if (!en_s)
					next_st.state = wk_s ? RPMS_SLEEP : RPMS_OFF;
			end
			default: next_st.state = RPMS_OFF;
		endcase

		// A pin wake leaves the device as it would be with no main enable.
		if (next_st.state == RPMS_OFF && st.state != RPMS_OFF)
			next_st.csc = st.csc & CSC_PD_MASK | CSC_RESET;
		if (st.state == RPMS_OFF)
			next_st.csc = CSC_RESET;

		// Mode bits only matter once the main enable holds the device up.
		if (next_st.state == RPMS_ACTIVE && en_s)
			next_st.mode = decode_mode(next_st.csc);
		else if (next_st.state == RPMS_OFF)
			next_st.mode = RPMS_M_OFF;
		else if (next_st.state == RPMS_SLEEP)
			next_st.mode = RPMS_M_SLEEP;
		else
			next_st.mode = RPMS_M_1;

		// Recovery from a low-power mode holds off full operation.
		if (st.mode == RPMS_M_STANDBY && next_st.mode != RPMS_M_STANDBY)
			next_st.rec_cnt = 32'(STANDBY_CYC);
		else if (st.mode == RPMS_M_1 && next_st.mode != RPMS_M_1
			&& next_st.mode != RPMS_M_OFF && next_st.mode != RPMS_M_SLEEP)
			next_st.rec_cnt = 32'(MODE1_CYC);

		next_st.dsup = next_st.state != RPMS_OFF;
		next_st.osc = next_st.state == RPMS_SETTLE
			|| next_st.state == RPMS_WAKE_WAIT
			|| next_st.state == RPMS_ACTIVE;
		next_st.fast = next_st.state == RPMS_WAKE_WAIT
			|| next_st.state == RPMS_ACTIVE;
		next_st.ready = st.fast && next_st.fast;
		next_st.tx = next_st.mode == RPMS_M_3 || next_st.mode == RPMS_M_4;
		next_st.txh = next_st.mode == RPMS_M_3;
		next_st.rx = next_st.tx || next_st.mode == RPMS_M_2;
		next_st.s5 = next_st.csc[CSC_SUPPLY5_BIT];
		next_st.full_op = next_st.fast && next_st.rec_cnt == 32'h0000_0000
			&& next_st.mode != RPMS_M_STANDBY
			&& next_st.mode != RPMS_M_1;
		// Fast output is the system clock itself only in a real chip; here the
		// pin toggles every cycle, the slow clock drives it in sleep and settle, and it is low when off.
		if (next_st.fast)
			next_st.clk_out = !st.clk_out;
		else if (next_st.state != RPMS_OFF)
			next_st.clk_out = next_st.aux_clk;
		else
			next_st.clk_out = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.csc <= CSC_RESET;
			st.state <= RPMS_OFF;
			st.mode <= RPMS_M_OFF;
		end else begin
			st <= next_st;
		end
	end

	assign digital_supply_on = st.dsup;
	assign oscillator_on = st.osc;
	assign transmitter_on = st.tx;
	assign transmitter_half_power = st.txh;
	assign receiver_on = st.rx;
	assign supply_5v_config = st.s5;
	assign host_clock_output = st.clk_out;
	assign host_clock_fast = st.fast;
	assign host_ready = st.ready;
	assign full_operation = st.full_op;

	AST_OFF_ALL: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_OFF |-> !st.dsup && !st.tx && !st.rx && !st.fast)
		else $error("power down leaves something on");
	AST_SLEEP_SLOW: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_SLEEP |-> st.dsup && !st.fast && !st.tx && !st.rx)
		else $error("sleep state outputs wrong");
	AST_WAKE_EDGE: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_OFF && wk_s && !st.wk_prev |=> st.state == RPMS_SETTLE)
		else $error("wake edge did not start settling");
	AST_SETTLE_TIME: assert property (@(posedge aclk)
		disable iff (!aresetn)
		$rose(st.osc) |-> !st.fast [*2])
		else $error("fast clock before settling");
	AST_READY_AFTER: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.ready |-> $past(st.fast))
		else $error("ready before clock switch");
	AST_WAKE_FALL: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_WAKE_WAIT && st.cnt == 32'h0000_0000 && !en_s
		&& !wk_s |=> st.state == RPMS_OFF)
		else $error("unconfirmed wake did not power down");
	AST_CONFIRM: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_WAKE_WAIT && en_s |=> st.state == RPMS_ACTIVE)
		else $error("main enable did not confirm wake");
	AST_MODE_GATE: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.tx |-> $past(en_s))
		else $error("mode bits acted without main enable");
	AST_FULL: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.mode == RPMS_M_4 |-> st.tx && st.rx && !st.txh)
		else $error("mode 4 outputs wrong");
	AST_PD_CLEAR: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st.state == RPMS_OFF && $past(st.state) == RPMS_OFF
		|-> st.csc == CSC_RESET)
		else $error("control not cleared in power down");
endmodule

// [bench/rpms_host_model.sv]
`timescale 1ns/1ps
module rpms_host_model #(
	parameter int GAP_CYC = 12
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Levels the bench asks for.
	input wire logic want_main,
	input wire logic want_wake,
	// Enable pins toward the device.
	output logic main_enable,
	output logic secondary_wake_pin
);
	int gap;

	// Only one pin moves at a time, then a quiet gap, so both never rise
	// together. The gap is scaled down from milliseconds to keep runs short.
	always @(posedge aclk) begin
		if (!aresetn) begin
			main_enable <= 1'b0;
			secondary_wake_pin <= 1'b0;
			gap <= 0;
		end else if (gap > 0) begin
			gap <= gap - 1;
		end else if (want_main != main_enable) begin
			main_enable <= want_main;
			gap <= GAP_CYC;
		end else if (want_wake != secondary_wake_pin) begin
			secondary_wake_pin <= want_wake;
			gap <= GAP_CYC;
		end
	end
endmodule

// [bench/reader_power_mode_sequencer_bench.sv]
`timescale 1ns/1ps
module reader_power_mode_sequencer_bench;
	import rpms_pkg::*;
	localparam int ST = 8, WK = 20, SB = 20, M1 = 10;
	logic aclk = 0, aresetn = 0, want_main = 0, want_wake = 0;
	logic main_enable, secondary_wake_pin;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic dsup, osc, tx, half, rx, s5, hclk, fast, rdy, fullop, r;
	logic [3:0] pins;
	assign pins = {tx, half, rx, s5};
	int fails = 0, checks_done = 0, csc_m = 1, n;
	logic [7:0] vals[$] = '{8'h21, 8'h31, 8'h03, 8'h01, 8'h81, 8'h20,
		8'h30, 8'h02, 8'h00, 8'h80};

	initial forever #5 aclk = ~aclk;

	rpms_host_model #(.GAP_CYC(12)) rpms_host_model_i (.aclk(aclk),
		.aresetn(aresetn), .want_main(want_main), .want_wake(want_wake),
		.main_enable(main_enable), .secondary_wake_pin(secondary_wake_pin));

	rpms_sequencer #(.SETTLE_CYC(ST), .WAKE_CYC(WK), .STANDBY_CYC(SB),
		.MODE1_CYC(M1)) rpms_sequencer_i (.aclk(aclk), .aresetn(aresetn),
		.main_enable(main_enable), .secondary_wake_pin(secondary_wake_pin),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .digital_supply_on(dsup),
		.oscillator_on(osc), .transmitter_on(tx),
		.transmitter_half_power(half), .receiver_on(rx),
		.supply_5v_config(s5), .host_clock_output(hclk),
		.host_clock_fast(fast), .host_ready(rdy), .full_operation(fullop));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task hang;
		fails++;
		give_verdict();
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 50) hang();
	endtask

	task axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 50) hang();
	endtask

	// Selector 0 watches host_ready, 1 full_operation, 2 the digital supply.
	task wait_sig(input int which, input logic lvl, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge aclk);
			if ((which == 0 ? rdy : which == 1 ? fullop : dsup) === lvl) break;
		end
		if (n == lim) hang();
	endtask

	function automatic logic [3:0] exp_pins(int c);
		logic t, v;
		t = !c[7] && c[5];
		v = !c[7] && (c[5] || c[1]);
		return {t, t && c[4], v, logic'(c[0])};
	endfunction

	task set_csc(input logic [7:0] v);
		axw(CSC_OFFSET, {24'h0, v});
		chk(32'(resp), 32'(RESP_OKAY));
		csc_m = v;
		repeat (3) @(posedge aclk);
		chk(32'(pins), 32'(exp_pins(csc_m)));
		axr(CSC_OFFSET);
		chk(rd, 32'(csc_m));
	endtask

	initial begin
		void'($urandom(32'h45a2));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({dsup, osc, tx, rx, fast, rdy}), 32'h0);
		axw(CSC_OFFSET, 32'h21);
		chk(32'(resp), 32'(RESP_OKAY));
		axr(CSC_OFFSET);
		chk(rd, 32'h01);
		axw(8'h08, 32'h5a);
		chk(32'(resp), 32'(RESP_SLVERR));
		axr(8'h08);
		chk(32'(resp), 32'(RESP_SLVERR));
		chk(rd, 32'h0);
		$display("test power_down done");
		// A lone wake pulse must time out back to sleep.
		want_wake <= 1'b1;
		wait_sig(0, 1'b1, 200);
		chk(32'({dsup, osc, fast}), 32'h7);
		r = hclk;
		@(posedge aclk);
		chk(32'(hclk), 32'(!r));
		wait_sig(0, 1'b0, WK + 20);
		chk(32'(n >= WK - 3), 32'h1);
		repeat (3) @(posedge aclk);
		chk(32'({dsup, osc, fast, tx, rx}), 32'h10);
		// The slow clock must toggle twice per divider period while asleep.
		r = hclk;
		for (n = 0; n < AUX_DIV && hclk === r; n++) @(posedge aclk);
		if (n == AUX_DIV) hang();
		r = hclk;
		for (n = 0; n < AUX_DIV && hclk === r; n++) @(posedge aclk);
		chk(32'(n), 32'(AUX_DIV / 2));
		want_wake <= 1'b0;
		wait_sig(2, 1'b0, 200);
		chk(32'({osc, fast, hclk, tx}), 32'h0);
		$display("test pin_wake_timeout done");
		want_wake <= 1'b1;
		repeat (4) @(posedge aclk);
		want_main <= 1'b1;
		wait_sig(0, 1'b1, 200);
		repeat (WK + 10) @(posedge aclk);
		chk(32'({rdy, fast}), 32'h3);
		want_wake <= 1'b0;
		$display("test pin_wake_confirmed done");
		foreach (vals[i]) set_csc(vals[i]);
		repeat (6) set_csc(8'($urandom));
		$display("test mode_table done");
		for (int k = 0; k < 2; k++) begin
			set_csc(k == 0 ? 8'h81 : 8'h01);
			axw(CSC_OFFSET, 32'h21);
			wait_sig(1, 1'b1, SB + M1 + 50);
			chk(32'(n >= (k == 0 ? SB : M1) - 4), 32'h1);
			chk(32'(n <= (k == 0 ? SB : M1) + 6), 32'h1);
		end
		$display("test recovery done");
		csc_m = 1;
		want_main <= 1'b0;
		wait_sig(2, 1'b0, 300);
		axr(CSC_OFFSET);
		chk(rd, 32'(csc_m));
		chk(32'({tx, rx, fast, rdy}), 32'h0);
		$display("test back_to_off done");
		give_verdict();
	end
endmodule
